// ### verilog/reset_dist_pkg.sv
// Constants for the board reset distribution block.
// Assumes a 40 MHz core clock and a single AHB-Lite slave.
package reset_dist_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int RST_MIN_NS = 1000;
	localparam int RST_MIN_CYCLES = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int STRETCH_W = 8;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] CTRL_OFFS = 12'h000;
	localparam logic [11:0] STATUS_OFFS = 12'h004;
	localparam int SYSCTRL_BIT = 0;
	localparam int TRIG_POS = 8;
	localparam int DOM_POS = 0;
	localparam int SRC_POS = 8;
	localparam logic CTRL_RESET = 1'b0;

	// ----------------------------------------
	// Sources: 0 switch, 1 watchdog, 2 bus reset in,
	// 3 alternate hot, 4 io, 5 bus system sw, 6 local sw, 7 csr
	// ----------------------------------------
	localparam int NUM_SRC = 8;
	localparam int NUM_SW = 5;
	localparam int NUM_DOM = 5;
	localparam logic [7:0] CPU_MASK = 8'h66;
	localparam logic [7:0] HOSTBR_MASK = 8'h2C;
	localparam logic [7:0] PCI_MASK = 8'hFF;
	localparam logic [7:0] ISA_MASK = 8'hBD;
	localparam logic [7:0] VME_MASK = 8'h23;

	// ----------------------------------------
	// AHB-Lite
	// ----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
endpackage

// ### verilog/reset_stretch.sv
// One reset source: optional two-stage synchroniser, then a minimum-width stretch.
// Assumes an active-high source level or pulse.
`timescale 1ns/1ps
module reset_stretch #(
	parameter bit SYNC = 1'b0,
	parameter int CNT_W = 8,
	parameter int STRETCH = 40
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Source and result
	input wire logic srcIn,
	output logic active
);
	logic lvl;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	generate
		if (STRETCH < 1 || STRETCH > (2 ** CNT_W) - 1) begin : g_chk
			$error("reset_stretch: STRETCH does not fit CNT_W");
		end
		if (SYNC) begin : g_sync
			logic meta_q;
			logic sync_q;
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= srcIn;
					sync_q <= meta_q;
				end
			end
			assign lvl = sync_q;
		end else begin : g_direct
			assign lvl = srcIn;
		end
	endgenerate

	assign cnt_d = lvl ? CNT_W'(STRETCH) : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
	assign active = lvl | (cnt_q != '0);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// ### verilog/board_reset_distribution.sv
// Board reset distribution: gathers reset sources and drives five domain resets.
// Assumes resetn is the power-on reset and an AHB-Lite master on core_clk.
//
// Contract
// - Power-on resets all five domains; incoming bus system reset resets all but the bus.
// - Front switch resets PCI, ISA, and bus when system controller only.
// - Watchdog resets processor, PCI, and bus when system controller.
// - Alternate hot reset resets host bridge, PCI and ISA devices.
// - I/O reset bit resets only PCI and ISA devices.
// - Bridge system software reset resets all five domains, the bus only when system controller.
// - Bridge local software reset resets only processor and PCI devices.
// - Bridge CSR reset resets only PCI and ISA devices.
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module board_reset_distribution #(
	parameter int STRETCH = reset_dist_pkg::RST_MIN_CYCLES
) (
	// Clock and power-on reset
	input wire logic core_clk,
	input wire logic resetn,
	// Reset source pins, asynchronous
	input wire logic frontSwitchN,
	input wire logic watchdogN,
	input wire logic vmeSysResetInN,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Domain resets
	output logic cpuResetN,
	output logic hostBridgeResetN,
	output logic pciResetN,
	output logic isaResetN,
	// Bus system reset, open drain
	output logic vmeResetOut,
	output logic vmeResetOe
);
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic addrPhase;
	logic wrPend_q;
	logic [11:0] wrAddr_q;
	logic sysCtrl_q;
	logic [reset_dist_pkg::NUM_SW-1:0] trig_q;
	logic [reset_dist_pkg::NUM_SW-1:0] trig_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic wrCtrl;
	logic [reset_dist_pkg::NUM_SRC-1:0] srcAct;
	logic [reset_dist_pkg::NUM_DOM-1:0] domAct;
	logic [31:0] ctrlView;
	logic [31:0] statusView;
	logic [reset_dist_pkg::NUM_DOM-1:0] dom_q;
	logic [3:0] domN_q;
	logic busMeta_q;
	logic busSync_q;
	logic [2:0] oeHist_q;
	logic ownDrive;

	assign addrPhase = hsel & hready & (htrans == reset_dist_pkg::HTRANS_NONSEQ);
	assign wrCtrl = wrPend_q & (wrAddr_q == reset_dist_pkg::CTRL_OFFS);
	assign trig_d = wrCtrl ?
		hwdata[reset_dist_pkg::TRIG_POS +: reset_dist_pkg::NUM_SW] : '0;
	assign ctrlView = {31'h0000_0000, sysCtrl_q};
	assign statusView = {16'h0000, srcAct, 3'h0, domAct};

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (haddr[11:0] == reset_dist_pkg::CTRL_OFFS && haddr[31:12] == 20'h0_0000) begin
			rdata_d = ctrlView;
		end else if (haddr[11:0] == reset_dist_pkg::STATUS_OFFS && haddr[31:12] == 20'h0_0000) begin
			rdata_d = statusView;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 12'h000;
			rdata_q <= 32'h0000_0000;
		end else begin
			wrPend_q <= addrPhase & hwrite & (haddr[31:12] == 20'h0_0000);
			wrAddr_q <= haddr[11:0];
			if (addrPhase && !hwrite) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sysCtrl_q <= reset_dist_pkg::CTRL_RESET;
			trig_q <= '0;
		end else begin
			trig_q <= trig_d;
			if (wrCtrl) begin
				sysCtrl_q <= hwdata[reset_dist_pkg::SYSCTRL_BIT];
			end
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = reset_dist_pkg::HRESP_OKAY;

	// ----------------------------------------
	// Incoming bus reset
	// ----------------------------------------
	// Own drive returns on the shared line; masked until the sync sees it gone
	assign ownDrive = dom_q[4] | (|oeHist_q);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busMeta_q <= 1'b0;
			busSync_q <= 1'b0;
			oeHist_q <= 3'h7;
		end else begin
			busMeta_q <= ~vmeSysResetInN;
			busSync_q <= busMeta_q;
			oeHist_q <= {oeHist_q[1:0], dom_q[4]};
		end
	end

	// ----------------------------------------
	// Reset sources
	// ----------------------------------------
	reset_stretch #(
		.SYNC(1'b1),
		.CNT_W(reset_dist_pkg::STRETCH_W),
		.STRETCH(STRETCH)
	) u_switch (
		.core_clk(core_clk),
		.resetn(resetn),
		.srcIn(~frontSwitchN),
		.active(srcAct[0])
	);

	reset_stretch #(
		.SYNC(1'b1),
		.CNT_W(reset_dist_pkg::STRETCH_W),
		.STRETCH(STRETCH)
	) u_watchdog (
		.core_clk(core_clk),
		.resetn(resetn),
		.srcIn(~watchdogN),
		.active(srcAct[1])
	);

	reset_stretch #(
		.SYNC(1'b0),
		.CNT_W(reset_dist_pkg::STRETCH_W),
		.STRETCH(STRETCH)
	) u_busin (
		.core_clk(core_clk),
		.resetn(resetn),
		.srcIn(busSync_q & ~ownDrive),
		.active(srcAct[2])
	);

	// Software triggers: alternate hot, io, bus system, local, csr
	genvar gi;
	generate
		for (gi = 0; gi < reset_dist_pkg::NUM_SW; gi++) begin : g_sw
			reset_stretch #(
				.SYNC(1'b0),
				.CNT_W(reset_dist_pkg::STRETCH_W),
				.STRETCH(STRETCH)
			) u_sw (
				.core_clk(core_clk),
				.resetn(resetn),
				.srcIn(trig_q[gi]),
				.active(srcAct[3+gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Domain mapping
	// ----------------------------------------
	logic cpuHit;
	logic hbHit;
	logic pciHit;
	logic isaHit;
	logic vmeHit;

	assign cpuHit = |(srcAct & reset_dist_pkg::CPU_MASK);
	assign hbHit = |(srcAct & reset_dist_pkg::HOSTBR_MASK);
	assign pciHit = |(srcAct & reset_dist_pkg::PCI_MASK);
	assign isaHit = |(srcAct & reset_dist_pkg::ISA_MASK);
	// Incoming bus reset is already on the bus; redriving it would latch up
	assign vmeHit = sysCtrl_q & |(srcAct & reset_dist_pkg::VME_MASK);
	assign domAct = dom_q;

	// Power-on: every domain held in reset from the async reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dom_q <= '1;
		end else begin
			dom_q <= {vmeHit, isaHit, pciHit, hbHit, cpuHit};
		end
	end

	// Pin-facing copies, active low
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			domN_q <= 4'h0;
		end else begin
			domN_q <= ~{isaHit, pciHit, hbHit, cpuHit};
		end
	end

	assign cpuResetN = domN_q[0];
	assign hostBridgeResetN = domN_q[1];
	assign pciResetN = domN_q[2];
	assign isaResetN = domN_q[3];
	assign vmeResetOut = 1'b0;
	assign vmeResetOe = dom_q[4];
endmodule

// ### sim/reset_dist_asserts.sv
// Checker for the board reset distribution block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module reset_dist_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Source pins
	input wire logic frontSwitchN,
	input wire logic watchdogN,
	input wire logic vmeSysResetInN,
	// Domain resets
	input wire logic cpuResetN,
	input wire logic hostBridgeResetN,
	input wire logic pciResetN,
	input wire logic isaResetN,
	input wire logic vmeResetOe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence allLow;
		!(cpuResetN | hostBridgeResetN | pciResetN | isaResetN);
	endsequence
	por_all_a: assert property (disable iff (1'b0) !resetn |-> allLow)
		else $error("domain free in power-on reset");
	bus_in_a: assert property ($fell(vmeSysResetInN) && !vmeResetOe |-> ##[1:5] allLow)
		else $error("bus reset missed a domain");
	sw_dom_a: assert property ($fell(frontSwitchN) |-> ##[1:5] !pciResetN && !isaResetN)
		else $error("switch missed pci or isa");
	wd_dom_a: assert property ($fell(watchdogN) |-> ##[1:5] !cpuResetN && !pciResetN)
		else $error("watchdog missed cpu or pci");
	sw_hold_a: assert property (!frontSwitchN [*6] |-> !pciResetN && !isaResetN)
		else $error("switch reset not held");
	wd_hold_a: assert property (!watchdogN [*6] |-> !cpuResetN)
		else $error("watchdog reset not held");
	bus_hold_a: assert property ((!vmeSysResetInN && !vmeResetOe) [*6] |-> allLow)
		else $error("bus reset not held");
	oe_pci_a: assert property ($rose(vmeResetOe) |-> !pciResetN)
		else $error("bus driven without pci reset");
endmodule
bind board_reset_distribution reset_dist_asserts reset_dist_asserts_inst (
	.core_clk(core_clk),
	.resetn(resetn),
	.frontSwitchN(frontSwitchN),
	.watchdogN(watchdogN),
	.vmeSysResetInN(vmeSysResetInN),
	.cpuResetN(cpuResetN),
	.hostBridgeResetN(hostBridgeResetN),
	.pciResetN(pciResetN),
	.isaResetN(isaResetN),
	.vmeResetOe(vmeResetOe)
);

// ### sim/reset_sources_model.sv
// Far-side model: reset switch, watchdog and the shared bus reset line.
// Assumes press levels from the bench, active high.
`timescale 1ns/1ps
module reset_sources_model (
	// Requests and bus drive
	input wire logic [2:0] press,
	input wire logic vmeResetOe,
	// Source pins
	output logic frontSwitchN,
	output logic watchdogN,
	output logic vmeSysResetInN
);
	assign frontSwitchN = !press[0];
	assign watchdogN = !press[1];
	// Pulled-up line, low while any party drives it
	assign vmeSysResetInN = !(press[2] | vmeResetOe);
endmodule

// ### sim/board_reset_distribution_test.sv
// Bench for the board reset distribution block.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
module board_reset_distribution_test;
	logic core_clk = 1'b0, resetn = 1'b1, hsel = 1'b1, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, press = 3'h0;
	logic hreadyout, hresp, frontSwitchN, watchdogN, vmeSysResetInN, vmeResetOut, vmeResetOe;
	logic cpuResetN, hostBridgeResetN, pciResetN, isaResetN;
	logic [3:0] domMap [8] = '{4'hC, 4'h5, 4'hF, 4'hE, 4'hC, 4'hF, 4'h5, 4'hC};
	int failCount = 0, comparisons = 0, cycles = 0;
	board_reset_distribution #(.STRETCH(2)) board_reset_distribution_inst (
		.core_clk(core_clk),
		.resetn(resetn),
		.frontSwitchN(frontSwitchN),
		.watchdogN(watchdogN),
		.vmeSysResetInN(vmeSysResetInN),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.cpuResetN(cpuResetN),
		.hostBridgeResetN(hostBridgeResetN),
		.pciResetN(pciResetN),
		.isaResetN(isaResetN),
		.vmeResetOut(vmeResetOut),
		.vmeResetOe(vmeResetOe)
	);
	reset_sources_model reset_sources_model_inst (
		.press(press),
		.vmeResetOe(vmeResetOe),
		.frontSwitchN(frontSwitchN),
		.watchdogN(watchdogN),
		.vmeSysResetInN(vmeSysResetInN)
	);
	always #12.5 core_clk = !core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failCount++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge core_clk);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rdChk(input string what, input logic [31:0] a, exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(what, exp, q);
	endtask
	function automatic logic [31:0] doms();
		return {27'h0, vmeResetOe, !isaResetN, !pciResetN, !hostBridgeResetN, !cpuResetN};
	endfunction
	// Raise one source, compare the domains, then let it lapse
	task automatic fire(input int i, input logic ctl);
		logic [31:0] q;
		int n;
		logic vmeExp;
		vmeExp = ctl && (i < 2 || i == 5);
		bus(1'b1, 32'h0000_0000, {31'h0, ctl}, q);
		if (i < 3) begin
			@(posedge core_clk);
			press <= 3'h1 << i;
		end else begin
			bus(1'b1, 32'h0000_0000, {19'h0, 5'h1 << (i - 3), 7'h0, ctl}, q);
		end
		n = 0;
		while (pciResetN !== 1'b0 && n < 12) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("domains", {27'h0, vmeExp, domMap[i]}, doms());
		if (i < 3) begin
			rdChk("status", 32'h0000_0004, {16'h0, 8'h1 << i, 3'h0, vmeExp, domMap[i]});
			check("held domains", {27'h0, vmeExp, domMap[i]}, doms());
		end
		@(posedge core_clk);
		press <= 3'h0;
		repeat (30) @(posedge core_clk);
		#1;
		check("idle domains", 32'h0000_0000, doms());
		$display("source %0d controller %0b done", i, ctl);
	endtask
	initial begin
		logic [31:0] q;
		resetn <= 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		check("domains", 32'h0000_001F, doms());
		@(posedge core_clk);
		resetn <= 1'b1;
		repeat (20) @(posedge core_clk);
		rdChk("ctrl", 32'h0000_0000, 32'h0000_0000);
		rdChk("unmapped", 32'h0000_0008, 32'h0000_0000);
		bus(1'b1, 32'h0000_0000, 32'h0000_0001, q);
		rdChk("ctrl", 32'h0000_0000, 32'h0000_0001);
		check("response", 32'h0000_0000, {31'h0, hresp});
		check("bus drive level", 32'h0000_0000, {31'h0, vmeResetOut});
		$display("register test done");
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 8; i++) begin
				fire(i, c[0]);
			end
		end
		rdChk("status", 32'h0000_0004, 32'h0000_0000);
		stop_test();
	end
endmodule
